// ---- hw/ifc_consts.vh ----
/*
  Constants of the interrupt flag controller: register selects, bit
  positions, reset value, source order, vectors and edge codes.
  Assumes it is included by its bare name from the design file.
*/
`ifndef IFC_CONSTS_VH
`define IFC_CONSTS_VH

// ----------------------------------------
// register selects on the special register port
// ----------------------------------------
`define IFC_SEL_PRIM0 3'h0
`define IFC_SEL_PRIM1 3'h1
`define IFC_SEL_PRIM2 3'h2
`define IFC_SEL_GRP0 3'h3
`define IFC_SEL_GRP1 3'h4
`define IFC_SEL_GRP2 3'h5
`define IFC_SEL_EDGE 3'h6
`define IFC_RESET_VAL 8'h00

// ----------------------------------------
// bit positions
// ----------------------------------------
`define IFC_C0_GIE 0
`define IFC_C0_E0EN 1
`define IFC_C0_E1EN 2
`define IFC_C0_ACEN 3
`define IFC_C0_E0F 4
`define IFC_C0_E1F 5
`define IFC_C0_ACF 6
`define IFC_C1_TB0EN 0
`define IFC_C1_TB1EN 1
`define IFC_C1_MF0EN 2
`define IFC_C1_MF1EN 3
`define IFC_C1_TIME_BASE0_REQ_FLAG 4
`define IFC_C1_TIME_BASE1_REQ_FLAG 5
`define IFC_C1_GROUP0_REQ_FLAG 6
`define IFC_C1_GROUP1_REQ_FLAG 7
`define IFC_C2_MF2EN 0
`define IFC_C2_GROUP2_REQ_FLAG 4

// ----------------------------------------
// primary source index, highest priority first
// ----------------------------------------
`define IFC_SRC_EXT0 0
`define IFC_SRC_EXT1 1
`define IFC_SRC_AC 2
`define IFC_SRC_TB0 3
`define IFC_SRC_TB1 4
`define IFC_SRC_MF0 5
`define IFC_SRC_MF1 6
`define IFC_SRC_MF2 7

// ----------------------------------------
// vectors (placement is arbitrary)
// ----------------------------------------
`define IFC_PC_W 13
`define IFC_VEC_EXT0 13'h0004
`define IFC_VEC_EXT1 13'h0008
`define IFC_VEC_AC 13'h000C
`define IFC_VEC_TB0 13'h0010
`define IFC_VEC_TB1 13'h0014
`define IFC_VEC_MF0 13'h0018
`define IFC_VEC_MF1 13'h001C
`define IFC_VEC_MF2 13'h0020

// ----------------------------------------
// edge selector codes
// ----------------------------------------
`define IFC_EDGE_OFF 2'h0
`define IFC_EDGE_RISE 2'h1
`define IFC_EDGE_FALL 2'h2
`define IFC_EDGE_BOTH 2'h3

`endif

// ---- hw/ifc_core.v ----
/*
  Interrupt flag controller: request flags, enables, edge detection on two
  external pins, grouped requests, fixed priority arbitration, stack push
  and pop requests to the core, and wake-up from low-power modes.
  Assumes: event inputs are one-cycle pulses on clk; the core samples
  irq_accept with push_pc and vector_addr; pins are asynchronous.
*/
// Overview of operation
// - a source event sets its flag whatever the enables say, except a pin edge, which needs its pin enable.
// - a flag with its enable low stays recorded but causes no jump.
// - with the global enable low no source causes a jump.
// - on acceptance push next address and load the source vector.
// - return from interrupt pops the saved address from the stack.
// - acceptance clears the global enable, so no nesting occurs.
// - events while blocked still set their flags for later service.
// - a full stack holds off acceptance; the flag stays pending.
// - simultaneous enabled requests are resolved by fixed priority.
// - any flag becoming set wakes the device from sleep or idle.
// - a selected edge on an external pin sets that pin flag.
// - edge code 00 off, 01 rising, 10 falling, 11 both edges.
// - pin acts only with enable, pin-share routing and input direction.
// - servicing a pin interrupt clears its flag and the global enable.
// - a group flag sets when any grouped source request becomes set.
// - servicing a group clears only the group flag, not source flags.
// - primary register 0 layout: ac, pin1, pin0 flags, enables, global.
// - primary register 1 holds group1, group0, tb1, tb0 flags and enables.
// - primary register 2 holds group2 flag bit 4, enable bit 0.
// - group register 0 holds standard timer match flags and enables.
// - group register 1 holds low supply, eeprom, serial, adc flags, enables.
// - group register 2 holds compact timer flags bits 5,4, enables 1,0.
`timescale 1ns/1ns
`default_nettype none
`include "ifc_consts.vh"

module ifc_core (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // special register port
  input wire [2:0] reg_sel,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // core and stack
  input wire [`IFC_PC_W-1:0] pc_next,
  input wire instr_boundary,
  input wire stack_full,
  input wire return_from_interrupt,
  output reg irq_accept,
  output reg [`IFC_PC_W-1:0] push_pc,
  output reg [`IFC_PC_W-1:0] vector_addr,
  output reg stack_pop,
  output reg wake_up,
  // external pins and their routing
  input wire ext_irq_pin_zero,
  input wire ext_irq_pin_one,
  input wire [1:0] pin_share_sel,
  input wire [1:0] port_dir_input,
  // peripheral events, one-cycle pulses
  input wire autoconv_evt,
  input wire time_base0_evt,
  input wire time_base1_evt,
  input wire [3:0] std_timer_evt,
  input wire [3:0] misc_evt,
  input wire [1:0] compact_timer_evt
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg global_irq_enable_q;
  reg [7:0] prim_flag_q;
  reg [7:0] prim_en_q;
  wire [3:0] grp0_flag_q;
  wire [3:0] grp0_en_q;
  wire [3:0] grp0_flag_d;
  wire grp0_hit;
  wire [3:0] grp1_flag_q;
  wire [3:0] grp1_en_q;
  wire [3:0] grp1_flag_d;
  wire grp1_hit;
  wire [1:0] grp2_flag_q;
  wire [1:0] grp2_en_q;
  wire [1:0] grp2_flag_d;
  wire grp2_hit;
  reg [3:0] ext_edge_select_reg_q;
  reg [1:0] pin_s1_q;
  reg [1:0] pin_s2_q;
  reg [1:0] pin_s3_q;

  reg global_irq_enable_d;
  reg [7:0] prim_flag_d;
  reg [7:0] prim_en_d;
  reg [7:0] prim_sw;
  reg [7:0] pick;
  reg [1:0] edge_hit;
  reg [1:0] esel;
  reg [`IFC_PC_W-1:0] vec_d;
  reg [7:0] rd_mux;
  integer i;
  integer j;

  wire wr_c0 = reg_wr & (reg_sel == `IFC_SEL_PRIM0);
  wire wr_c1 = reg_wr & (reg_sel == `IFC_SEL_PRIM1);
  wire wr_c2 = reg_wr & (reg_sel == `IFC_SEL_PRIM2);
  wire wr_g0 = reg_wr & (reg_sel == `IFC_SEL_GRP0);
  wire wr_g1 = reg_wr & (reg_sel == `IFC_SEL_GRP1);
  wire wr_g2 = reg_wr & (reg_sel == `IFC_SEL_GRP2);
  wire wr_ed = reg_wr & (reg_sel == `IFC_SEL_EDGE);

  // ----------------------------------------
  // external pins
  // ----------------------------------------
  // second and third stages feed edge detection; first stage is never tapped
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      pin_s3_q <= 2'h0;
    end else begin
      pin_s1_q <= {ext_irq_pin_one, ext_irq_pin_zero};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  wire [1:0] pin_rise = pin_s2_q & ~pin_s3_q;
  wire [1:0] pin_fall = ~pin_s2_q & pin_s3_q;
  wire [1:0] pin_ok = prim_en_q[1:0] & pin_share_sel & port_dir_input;

  always @* begin
    edge_hit = 2'h0;
    esel = 2'h0;
    for (i = 0; i < 2; i = i + 1) begin
      esel = ext_edge_select_reg_q[2*i +: 2];
      case (esel)
        `IFC_EDGE_RISE: edge_hit[i] = pin_ok[i] & pin_rise[i];
        `IFC_EDGE_FALL: edge_hit[i] = pin_ok[i] & pin_fall[i];
        `IFC_EDGE_BOTH: edge_hit[i] = pin_ok[i] & (pin_rise[i] | pin_fall[i]);
        default: edge_hit[i] = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // grouped source flags
  // ----------------------------------------
  // hit comes from the next flag value, so the group flag sets on the same edge
  ifc_grp #(.W(4)) u_grp0 (.clk(clk), .rst_b(rst_b), .wr(wr_g0),
    .wdata(reg_wdata), .evt(std_timer_evt),
    .flag_q(grp0_flag_q), .en_q(grp0_en_q),
    .flag_d(grp0_flag_d), .hit(grp0_hit));

  ifc_grp #(.W(4)) u_grp1 (.clk(clk), .rst_b(rst_b), .wr(wr_g1),
    .wdata(reg_wdata), .evt(misc_evt),
    .flag_q(grp1_flag_q), .en_q(grp1_en_q),
    .flag_d(grp1_flag_d), .hit(grp1_hit));

  ifc_grp #(.W(2)) u_grp2 (.clk(clk), .rst_b(rst_b), .wr(wr_g2),
    .wdata(reg_wdata), .evt(compact_timer_evt),
    .flag_q(grp2_flag_q), .en_q(grp2_en_q),
    .flag_d(grp2_flag_d), .hit(grp2_hit));

  wire [7:0] prim_set = {grp2_hit, grp1_hit, grp0_hit, time_base1_evt,
    time_base0_evt, autoconv_evt, edge_hit};

  // ----------------------------------------
  // arbitration
  // ----------------------------------------
  wire [7:0] prim_req = prim_flag_q & prim_en_q;
  wire take = global_irq_enable_q & ~stack_full & instr_boundary & (|prim_req);

  always @* begin
    pick = 8'h00;
    for (j = 7; j >= 0; j = j - 1) begin
      if (prim_req[j]) begin
        pick = 8'h00;
        pick[j] = 1'b1;
      end
    end
  end

  always @* begin
    case (pick)
      8'h01: vec_d = `IFC_VEC_EXT0;
      8'h02: vec_d = `IFC_VEC_EXT1;
      8'h04: vec_d = `IFC_VEC_AC;
      8'h08: vec_d = `IFC_VEC_TB0;
      8'h10: vec_d = `IFC_VEC_TB1;
      8'h20: vec_d = `IFC_VEC_MF0;
      8'h40: vec_d = `IFC_VEC_MF1;
      8'h80: vec_d = `IFC_VEC_MF2;
      default: vec_d = vector_addr;
    endcase
  end

  // ----------------------------------------
  // primary flags and enables
  // ----------------------------------------
  always @* begin
    prim_sw = prim_flag_q;
    prim_en_d = prim_en_q;
    if (wr_c0) begin
      prim_sw[`IFC_SRC_EXT0] = reg_wdata[`IFC_C0_E0F];
      prim_sw[`IFC_SRC_EXT1] = reg_wdata[`IFC_C0_E1F];
      prim_sw[`IFC_SRC_AC] = reg_wdata[`IFC_C0_ACF];
      prim_en_d[`IFC_SRC_EXT0] = reg_wdata[`IFC_C0_E0EN];
      prim_en_d[`IFC_SRC_EXT1] = reg_wdata[`IFC_C0_E1EN];
      prim_en_d[`IFC_SRC_AC] = reg_wdata[`IFC_C0_ACEN];
    end
    if (wr_c1) begin
      prim_sw[`IFC_SRC_TB0] = reg_wdata[`IFC_C1_TIME_BASE0_REQ_FLAG];
      prim_sw[`IFC_SRC_TB1] = reg_wdata[`IFC_C1_TIME_BASE1_REQ_FLAG];
      prim_sw[`IFC_SRC_MF0] = reg_wdata[`IFC_C1_GROUP0_REQ_FLAG];
      prim_sw[`IFC_SRC_MF1] = reg_wdata[`IFC_C1_GROUP1_REQ_FLAG];
      prim_en_d[`IFC_SRC_TB0] = reg_wdata[`IFC_C1_TB0EN];
      prim_en_d[`IFC_SRC_TB1] = reg_wdata[`IFC_C1_TB1EN];
      prim_en_d[`IFC_SRC_MF0] = reg_wdata[`IFC_C1_MF0EN];
      prim_en_d[`IFC_SRC_MF1] = reg_wdata[`IFC_C1_MF1EN];
    end
    if (wr_c2) begin
      prim_sw[`IFC_SRC_MF2] = reg_wdata[`IFC_C2_GROUP2_REQ_FLAG];
      prim_en_d[`IFC_SRC_MF2] = reg_wdata[`IFC_C2_MF2EN];
    end
    // service clears only the chosen primary flag; set still wins
    prim_flag_d = (prim_sw & ~(take ? pick : 8'h00)) | prim_set;
    if (take) begin
      global_irq_enable_d = 1'b0;
    end else if (wr_c0) begin
      global_irq_enable_d = reg_wdata[`IFC_C0_GIE];
    end else begin
      global_irq_enable_d = global_irq_enable_q;
    end
  end

  // ----------------------------------------
  // register read image
  // ----------------------------------------
  always @* begin
    case (reg_sel)
      `IFC_SEL_PRIM0: rd_mux = {1'b0, prim_flag_q[2:0], prim_en_q[2:0],
        global_irq_enable_q};
      `IFC_SEL_PRIM1: rd_mux = {prim_flag_q[6:3], prim_en_q[6:3]};
      `IFC_SEL_PRIM2: rd_mux = {3'h0, prim_flag_q[7], 3'h0, prim_en_q[7]};
      `IFC_SEL_GRP0: rd_mux = {grp0_flag_q, grp0_en_q};
      `IFC_SEL_GRP1: rd_mux = {grp1_flag_q, grp1_en_q};
      `IFC_SEL_GRP2: rd_mux = {2'h0, grp2_flag_q, 2'h0, grp2_en_q};
      `IFC_SEL_EDGE: rd_mux = {4'h0, ext_edge_select_reg_q};
      default: rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      global_irq_enable_q <= 1'b0;
      prim_flag_q <= `IFC_RESET_VAL;
      prim_en_q <= `IFC_RESET_VAL;
      ext_edge_select_reg_q <= 4'h0;
    end else begin
      global_irq_enable_q <= global_irq_enable_d;
      prim_flag_q <= prim_flag_d;
      prim_en_q <= prim_en_d;
      if (wr_ed) begin
        ext_edge_select_reg_q <= reg_wdata[3:0];
      end
    end
  end

  // ----------------------------------------
  // outputs to core and stack
  // ----------------------------------------
  // pc is captured with the accept so the core may move on afterwards
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_accept <= 1'b0;
      push_pc <= {`IFC_PC_W{1'b0}};
      vector_addr <= {`IFC_PC_W{1'b0}};
      stack_pop <= 1'b0;
      wake_up <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      irq_accept <= take;
      if (take) begin
        push_pc <= pc_next;
        vector_addr <= vec_d;
      end
      stack_pop <= return_from_interrupt;
      // a flag already set gives no new wake
      wake_up <= |(prim_flag_d & ~prim_flag_q)
        | |(grp0_flag_d & ~grp0_flag_q)
        | |(grp1_flag_d & ~grp1_flag_q)
        | |(grp2_flag_d & ~grp2_flag_q);
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

endmodule

// ----------------------------------------
// one group of source flags with their enables
// ----------------------------------------
// flags sit in the upper nibble of a write, enables in the lower one
module ifc_grp #(
  parameter W = 4
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // register write
  input wire wr,
  input wire [7:0] wdata,
  // source events, one-cycle pulses
  input wire [W-1:0] evt,
  // group state
  output reg [W-1:0] flag_q,
  output reg [W-1:0] en_q,
  output wire [W-1:0] flag_d,
  output wire hit
);

  wire [W-1:0] en_d = wr ? wdata[0 +: W] : en_q;

  // event wins over a software clear in the same cycle
  assign flag_d = (wr ? wdata[4 +: W] : flag_q) | evt;
  // a grouped request counts when flag and own enable newly meet
  assign hit = |(flag_d & en_d & ~(flag_q & en_q));

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= {W{1'b0}};
      en_q <= {W{1'b0}};
    end else begin
      flag_q <= flag_d;
      en_q <= en_d;
    end
  end

endmodule

`default_nettype wire

// ---- verif/ifc_core_properties.sv ----
/* Port checker for ifc_core.
   Assumes it is bound to ifc_core and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
`include "ifc_consts.vh"
module ifc_core_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [2:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // core side
  input wire logic [12:0] pc_next,
  input wire logic instr_boundary,
  input wire logic stack_full,
  input wire logic return_from_interrupt,
  input wire logic irq_accept,
  input wire logic [12:0] push_pc,
  input wire logic [12:0] vector_addr,
  input wire logic stack_pop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----------------
  // global enable shadow
  // ----------------
  // may stay high one cycle too long after an accept: errs on the lenient side
  logic gie_q;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) gie_q <= 1'b0;
    else if (reg_wr && reg_sel == `IFC_SEL_PRIM0) gie_q <= reg_wdata[0];
    else if (irq_accept) gie_q <= 1'b0;
  end
  a_accept_gated: assert property (irq_accept |-> $past(gie_q && instr_boundary))
    else $error("accept without global enable");
  a_full_blocks: assert property (irq_accept |-> !$past(stack_full))
    else $error("accept while stack full");
  a_no_nesting: assert property (irq_accept |=> !irq_accept ##1 (!irq_accept
    || $past(reg_wr && reg_sel == `IFC_SEL_PRIM0 && reg_wdata[0], 2)))
    else $error("accept too soon after accept");
  a_pop_follows: assert property (return_from_interrupt |=> stack_pop)
    else $error("no pop after return");
  a_vector_known: assert property (irq_accept |-> vector_addr[1:0] == 2'h0)
    else $error("vector misaligned");
  a_push_next: assert property (irq_accept |-> push_pc == $past(pc_next))
    else $error("pushed address wrong");
  a_push_held: assert property (!irq_accept |-> $stable(push_pc) && $stable(vector_addr))
    else $error("push or vector moved");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_unmapped_zero: assert property (reg_rd && reg_sel == 3'h7 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_prim2_reserved: assert property (reg_rd && reg_sel == `IFC_SEL_PRIM2 |=> (reg_rdata & 8'hEE) == 8'h00)
    else $error("reserved bit set");
  a_grp2_reserved: assert property (reg_rd && reg_sel == `IFC_SEL_GRP2 |=> (reg_rdata & 8'hCC) == 8'h00)
    else $error("reserved bit set");
  cover property (irq_accept && vector_addr == `IFC_VEC_MF1);
  cover property (stack_full && instr_boundary ##1 stack_full);
  cover property (return_from_interrupt ##1 stack_pop);
endmodule
bind ifc_core ifc_core_properties u_props (.clk, .rst_b, .reg_sel, .reg_wr, .reg_rd,
  .reg_wdata, .reg_rdata, .pc_next, .instr_boundary, .stack_full, .return_from_interrupt,
  .irq_accept, .push_pc, .vector_addr, .stack_pop);
`default_nettype wire

// ---- verif/ifc_cpu_model.sv ----
/* Core and stack model facing ifc_core.
   Assumes one clock; the bench may hold back returns and slow the core. */
`timescale 1ns/1ns
`default_nettype none
module ifc_cpu_model #(
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bench controls
  input wire logic hold_ret,
  input wire logic slow,
  // controller side
  input wire logic irq_accept,
  input wire logic stack_pop,
  output logic [12:0] pc_next,
  output logic instr_boundary,
  output logic stack_full,
  output logic return_from_interrupt
);
  logic [3:0] lvl_q;
  logic [2:0] tmr_q;
  assign stack_full = (lvl_q == 4'(DEPTH));
  // handlers return every eighth cycle, so the stack really fills
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_next <= 13'h0100;
      lvl_q <= 4'h0;
      tmr_q <= 3'h0;
      instr_boundary <= 1'b0;
      return_from_interrupt <= 1'b0;
    end else begin
      pc_next <= pc_next + 13'h0001;
      tmr_q <= tmr_q + 3'h1;
      instr_boundary <= !slow || !instr_boundary;
      lvl_q <= lvl_q + {3'h0, irq_accept} - {3'h0, stack_pop};
      return_from_interrupt <= tmr_q == 3'h7 && lvl_q != 4'h0 && !hold_ret;
    end
  end
endmodule
`default_nettype wire

// ---- verif/test_interrupt_flag_controller.sv ----
/* Self-checking bench for ifc_core with a core model.
   Assumes ifc_consts.vh is on the include path. */
`timescale 1ns/1ns
`default_nettype none
`include "ifc_consts.vh"
module test_interrupt_flag_controller;
  logic clk, rst_b, reg_wr, reg_rd, hold_ret, slow, rs;
  logic ext_irq_pin_zero, ext_irq_pin_one, instr_boundary, stack_full;
  logic return_from_interrupt, irq_accept, stack_pop, wake_up;
  logic [2:0] reg_sel;
  logic [7:0] reg_wdata, reg_rdata;
  logic [1:0] pin_share_sel, port_dir_input;
  logic [12:0] evs, pc_next, push_pc, vector_addr;
  logic [15:0] rd_q[$], vec_q[$];
  logic [7:0] w[0:6];
  int fails, checked;
  ifc_core u_dut (.*, .autoconv_evt(evs[0]), .time_base0_evt(evs[1]),
    .time_base1_evt(evs[2]), .std_timer_evt(evs[6:3]), .misc_evt(evs[10:7]),
    .compact_timer_evt(evs[12:11]));
  ifc_cpu_model u_cpu (.*);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----------------
  // bus cycles and checks
  // ----------------
  task automatic cmp(input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic take(ref logic [15:0] q[$], input logic [15:0] g);
    cmp(q.size() != 0 ? q.pop_front() : 16'hFFFF, g);
  endtask
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    reg_sel = s;
    reg_wdata = d;
    reg_wr = 1'b1;
    step();
    reg_wr = 1'b0;
    step();
  endtask
  task automatic rd(input logic [2:0] s, input logic [7:0] e);
    reg_sel = s;
    reg_rd = 1'b1;
    rd_q.push_back({8'h00, e});
    step();
    reg_rd = 1'b0;
    step();
  endtask
  task automatic ev(input logic [12:0] m, input logic e);
    logic seen;
    seen = 1'b0;
    evs = m;
    step();
    evs = 13'h0000;
    repeat (4) begin
      seen = seen | (wake_up === 1'b1);
      step();
    end
    cmp({15'h0, e}, {15'h0, seen});
  endtask
  task automatic drain();
    int k;
    k = 0;
    while (vec_q.size() != 0 && k < 40) begin
      step();
      k++;
    end
  endtask
  task automatic wrap_up();
    fails += rd_q.size() + vec_q.size();
    $display("TB: checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // results are taken as they appear, oldest note first
  always @(posedge clk) begin
    rs = reg_rd;
    #1;
    if (rs === 1'b1) take(rd_q, {8'h00, reg_rdata});
    if (irq_accept === 1'b1) take(vec_q, {3'h0, vector_addr});
  end
  initial begin
    #(100 * 5000);
    fails++;
    wrap_up();
  end
  initial begin
    {reg_wr, reg_rd, ext_irq_pin_zero, ext_irq_pin_one, hold_ret, slow} = 6'h00;
    {reg_sel, reg_wdata, pin_share_sel, port_dir_input, evs} = 28'h0;
    rst_b = 1'b0;
    void'($urandom(32'hA6F93254));
    repeat (4) @(posedge clk);
    #2 rst_b = 1'b1;
    step();
    for (int i = 0; i < 8; i++) rd(i[2:0], `IFC_RESET_VAL);
    $display("TB: reset values done");
    foreach (w[i]) w[i] = 8'($urandom);
    w[0][0] = 1'b0;
    for (int i = 0; i < 7; i++) wr(i[2:0], w[i]);
    rd(`IFC_SEL_PRIM0, w[0] & 8'h7F);
    rd(`IFC_SEL_PRIM1, w[1] | {|(w[4][7:4] & w[4][3:0]), |(w[3][7:4] & w[3][3:0]), 6'h0});
    rd(`IFC_SEL_PRIM2, (w[2] & 8'h11) | {3'h0, |(w[5][5:4] & w[5][1:0]), 4'h0});
    rd(`IFC_SEL_GRP0, w[3]);
    rd(`IFC_SEL_GRP1, w[4]);
    rd(`IFC_SEL_GRP2, w[5] & 8'h33);
    rd(`IFC_SEL_EDGE, w[6] & 8'h0F);
    for (int i = 6; i >= 0; i--) wr(i[2:0], 8'h00);
    $display("TB: register layout done");
    slow = 1'b1;
    ev(13'h0007, 1'b1);
    ev(13'h0002, 1'b0);
    rd(`IFC_SEL_PRIM0, 8'h40);
    rd(`IFC_SEL_PRIM1, 8'h30);
    wr(`IFC_SEL_PRIM0, 8'h41);
    step(4);
    wr(`IFC_SEL_PRIM0, 8'h48);
    wr(`IFC_SEL_PRIM1, 8'h33);
    vec_q = '{`IFC_VEC_AC, `IFC_VEC_TB0, `IFC_VEC_TB1};
    wr(`IFC_SEL_PRIM0, 8'h49);
    repeat (2) begin
      step(3);
      wr(`IFC_SEL_PRIM0, 8'h09);
    end
    drain();
    rd(`IFC_SEL_PRIM1, 8'h03);
    rd(`IFC_SEL_PRIM0, 8'h08);
    wr(`IFC_SEL_PRIM1, 8'h00);
    slow = 1'b0;
    step(24);
    $display("TB: priority done");
    pin_share_sel = 2'b11;
    port_dir_input = 2'b11;
    for (int c = 0; c < 4; c++) begin
      wr(`IFC_SEL_EDGE, {6'h0, c[1:0]});
      wr(`IFC_SEL_PRIM0, 8'h03);
      if (c[0]) vec_q.push_back(`IFC_VEC_EXT0);
      ext_irq_pin_zero = 1'b1;
      step(8);
      wr(`IFC_SEL_PRIM0, 8'h03);
      if (c[1]) vec_q.push_back(`IFC_VEC_EXT0);
      ext_irq_pin_zero = 1'b0;
      step(8);
      rd(`IFC_SEL_PRIM0, c[1] ? 8'h02 : 8'h03);
    end
    wr(`IFC_SEL_EDGE, 8'h04);
    for (int j = 0; j < 4; j++) begin
      logic [2:0] cf;
      cf = (j == 3) ? 3'h7 : 3'h7 ^ (3'h1 << j);
      pin_share_sel = {cf[1], 1'b1};
      port_dir_input = {cf[2], 1'b1};
      wr(`IFC_SEL_PRIM0, {5'h0, cf[0], 2'h0});
      ext_irq_pin_one = 1'b1;
      step(8);
      rd(`IFC_SEL_PRIM0, {2'h0, j == 3, 2'h0, cf[0], 2'h0});
      ext_irq_pin_one = 1'b0;
      step(4);
    end
    $display("TB: external pins done");
    wr(`IFC_SEL_GRP1, 8'h01);
    wr(`IFC_SEL_PRIM1, 8'h08);
    wr(`IFC_SEL_PRIM0, 8'h01);
    vec_q.push_back(`IFC_VEC_MF1);
    ev(13'h0080, 1'b1);
    drain();
    ev(13'h0778, 1'b1);
    rd(`IFC_SEL_GRP0, 8'hF0);
    rd(`IFC_SEL_GRP1, 8'hF1);
    rd(`IFC_SEL_PRIM1, 8'h08);
    ev(13'h1800, 1'b1);
    rd(`IFC_SEL_PRIM2, 8'h00);
    rd(`IFC_SEL_GRP2, 8'h30);
    $display("TB: grouped requests done");
    step(24);
    hold_ret = 1'b1;
    wr(`IFC_SEL_PRIM1, 8'h03);
    vec_q.push_back(`IFC_VEC_TB0);
    wr(`IFC_SEL_PRIM0, 8'h09);
    ev(13'h0002, 1'b1);
    drain();
    wr(`IFC_SEL_PRIM0, 8'h09);
    vec_q.push_back(`IFC_VEC_TB1);
    ev(13'h0004, 1'b1);
    drain();
    wr(`IFC_SEL_PRIM0, 8'h09);
    ev(13'h0001, 1'b1);
    step(6);
    rd(`IFC_SEL_PRIM0, 8'h49);
    vec_q.push_back(`IFC_VEC_AC);
    hold_ret = 1'b0;
    drain();
    $display("TB: full stack done");
    wrap_up();
  end
endmodule
`default_nettype wire
